// *** rtl/core_regs.sv ***
// memory map decode, program counter, status word, stack pointer, register banks
// Functional notes
// RULE1: one linear 64 KB space holds program memory, data memory and SFRs.
// RULE2: vector table 0000H-003FH, low byte even address, high byte odd.
// RULE3: reset and acknowledged sources fetch start address from their fixed slot.
// RULE4: table call takes its entry address from table 0040H-007FH.
// RULE5: short call reaches only entries between 0800H and 0FFFH.
// RULE6: 1024 bytes of high-speed RAM, also used as stack.
// RULE7: registers at FEE0H-FEFFH, four banks of eight bytes, also four pairs.
// RULE8: FA58H-FA7FH holds forty 4-bit LCD cells, usable as plain RAM.
// RULE9: software keeps away from unassigned SFR addresses.
// RULE10: counter steps by instruction length or loads branch target.
// RULE11: reset loads program counter from word at 0000H/0001H.
// RULE12: status word pushed on ack and push; restored by returns and pop. Here the plain return (i_ret) pops only the counter.
// RULE13: reset sets status word to 02H.
// RULE14: enable cleared by disable or ack, set by enable; off allows NMI only.
// RULE15: zero flag set on zero result, cleared otherwise.
// RULE16: two bank bits pick the register bank; bank switch writes them.
// RULE17: half carry set on carry out of or borrow into bit 3.
// RULE18: service level 0 blocks low priority maskables; enable also needed.
// RULE19: carry takes add/sub overflow, rotate shift-out and bit results.
// RULE20: stack pointer predecrements on write, postincrements on read; RAM only.
// RULE21: software loads stack pointer before any stack use.
// RULE22: status bits: enable 7, zero 6, bank 5 and 3, half 4, level 1, carry 0.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "core_regs_defines.svh"

module core_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_run,
  input  wire logic        i_pc_step,
  input  wire logic [2:0]  i_inst_len,
  input  wire logic        i_pc_load,
  input  wire logic [15:0] i_pc_target,
  input  wire logic        i_irq_ack,
  input  wire logic [4:0]  i_vec_slot,
  input  wire logic        i_ack_high,
  input  wire logic        i_brk,
  input  wire logic        i_table_call_instruction,
  input  wire logic [4:0]  i_table_call_instruction_idx,
  input  wire logic        i_short_call_instruction,
  input  wire logic [10:0] i_short_call_instruction_addr,
  input  wire logic        i_push_psw,
  input  wire logic        i_pop_psw,
  input  wire logic        i_ret,
  input  wire logic        i_interrupt_return_instruction,
  input  wire logic        i_di,
  input  wire logic        i_ei,
  input  wire logic        i_sel_bank,
  input  wire logic [1:0]  i_bank,
  input  wire logic        i_alu_upd,
  input  wire logic        i_alu_sub,
  input  wire logic [7:0]  i_alu_a,
  input  wire logic [7:0]  i_alu_b,
  input  wire logic        i_rot_upd,
  input  wire logic        i_shift_out,
  input  wire logic        i_cy_wr,
  input  wire logic        i_cy_val,
  input  wire logic        i_irq_req,
  input  wire logic        i_irq_low,
  input  wire logic        i_nmi_req,
  input  wire logic [2:0]  i_gr_sel,
  input  wire logic        i_gr_wr,
  input  wire logic [7:0]  i_gr_wdata,
  input  wire logic [1:0]  i_rp_sel,
  input  wire logic        i_rp_wr,
  input  wire logic [15:0] i_rp_wdata,
  output logic      [15:0] o_pc,
  output logic      [7:0]  o_psw,
  output logic      [15:0] o_sp,
  output logic      [7:0]  o_alu_result,
  output logic      [7:0]  o_gr_byte,
  output logic      [15:0] o_gr_pair,
  output logic             o_irq_ok,
  output logic             o_busy
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0] rom     [0:32767];
  logic [7:0] ram     [0:`RAM_DEPTH-1];
  logic [3:0] lcd     [0:`LCD_DEPTH-1];
  logic [15:0] pc_r;
  logic [7:0]  psw_r;
  logic [15:0] sp_r;
  logic [15:0] ret_pc_r;
  logic [7:0]  psw_save_r;
  logic [15:0] tgt_r;
  logic [15:0] vec_addr_r;
  logic        then_vec_r;
  logic        then_psw_r;
  core_regs_pkg::seq_state_type st_r;
  core_regs_pkg::seq_state_type st_nxt;

  // one linear address space, regions decoded from the full 16-bit address [RULE1]
  logic       in_rom;
  logic       in_lcd;
  logic       in_ram;
  logic       idle;
  logic [9:0] bus_ram_idx;
  logic [5:0] lcd_idx;
  logic [15:0] sp_dec;
  logic       push_ok;
  logic       pop_ok;
  logic [9:0] push_idx;
  logic [9:0] pop_idx;
  logic [9:0] bank_base;
  logic [8:0] alu_sum;
  logic [15:0] vec_word;

  assign in_rom      = (i_addr <= `ROM_LAST);
  assign in_lcd      = (i_addr >= `LCD_BASE) && (i_addr <= `LCD_TOP);
  assign in_ram      = (i_addr >= `RAM_BASE) && (i_addr <= `RAM_TOP);
  assign bus_ram_idx = 10'(i_addr - `RAM_BASE);
  assign lcd_idx     = 6'(i_addr - `LCD_BASE);
  assign idle        = (st_r == core_regs_pkg::ST_IDLE);
  // stack lives only in high-speed RAM; out-of-range stack writes are dropped [RULE20] [RULE6]
  assign sp_dec   = sp_r - 16'h0001;
  assign push_ok  = (sp_dec >= `RAM_BASE) && (sp_dec <= `RAM_TOP);
  assign pop_ok   = (sp_r >= `RAM_BASE) && (sp_r <= `RAM_TOP);
  assign push_idx = 10'(sp_dec - `RAM_BASE);
  assign pop_idx  = 10'(sp_r - `RAM_BASE);
  // bank bits sit split at 5 and 3; eight bytes per bank from FEE0H [RULE16] [RULE7]
  assign bank_base = `GREG_BASE + {4'h0, psw_r[`BIT_BANK_HI], psw_r[`BIT_BANK_LO], 3'h0};
  assign alu_sum   = i_alu_sub ? ({1'b0, i_alu_a} - {1'b0, i_alu_b})
                               : ({1'b0, i_alu_a} + {1'b0, i_alu_b});
  // vector words: low byte at even address, high byte at the next odd one [RULE2]
  assign vec_word  = {rom[15'(vec_addr_r + 16'h0001)], rom[15'(vec_addr_r)]};

  // ************************************************************
  // stack and vector sequencer
  // ************************************************************
  // next state; commands are taken only while idle, others ignored
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      core_regs_pkg::ST_BOOT:    st_nxt = i_run ? core_regs_pkg::ST_VEC : st_r;
      core_regs_pkg::ST_IDLE:
      begin
        if (i_irq_ack || i_brk || i_push_psw)
          st_nxt = core_regs_pkg::ST_PSH_PSW;
        else if (i_table_call_instruction || i_short_call_instruction)
          st_nxt = core_regs_pkg::ST_PSH_PCH;
        else if (i_pop_psw)
          st_nxt = core_regs_pkg::ST_POP_PSW;
        else if (i_ret || i_interrupt_return_instruction)
          st_nxt = core_regs_pkg::ST_POP_PCL;
      end
      core_regs_pkg::ST_PSH_PSW:
        st_nxt = then_vec_r ? core_regs_pkg::ST_PSH_PCH : core_regs_pkg::ST_IDLE;
      core_regs_pkg::ST_PSH_PCH: st_nxt = core_regs_pkg::ST_PSH_PCL;
      core_regs_pkg::ST_PSH_PCL:
        st_nxt = then_vec_r ? core_regs_pkg::ST_VEC : core_regs_pkg::ST_IDLE;
      core_regs_pkg::ST_POP_PCL: st_nxt = core_regs_pkg::ST_POP_PCH;
      core_regs_pkg::ST_POP_PCH:
        st_nxt = then_psw_r ? core_regs_pkg::ST_POP_PSW : core_regs_pkg::ST_IDLE;
      core_regs_pkg::ST_VEC:     st_nxt = core_regs_pkg::ST_IDLE;
      core_regs_pkg::ST_POP_PSW: st_nxt = core_regs_pkg::ST_IDLE;
      default:                   st_nxt = core_regs_pkg::ST_IDLE;
    endcase
  end

  // state register; boot waits for i_run so the program image can be loaded first
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      st_r <= core_regs_pkg::ST_BOOT;
    else
      st_r <= st_nxt;
  end

  // command context captured when a command is taken
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      vec_addr_r <= `VEC_RESET; // reset slot [RULE11] [RULE3]
      then_vec_r <= 1'b0;
      then_psw_r <= 1'b0;
      tgt_r      <= 16'h0000;
      ret_pc_r   <= 16'h0000;
      psw_save_r <= 8'h00;
    end
    else if (idle)
    begin
      ret_pc_r   <= pc_r;
      psw_save_r <= psw_r; // pushed as it stood before the ack clears enable [RULE12]
      then_vec_r <= i_irq_ack || i_brk || i_table_call_instruction;
      then_psw_r <= i_interrupt_return_instruction;
      tgt_r      <= {5'h01, i_short_call_instruction_addr}; // short call confined to 0800H-0FFFH [RULE5]
      if (i_irq_ack)
        vec_addr_r <= {10'h000, i_vec_slot, 1'b0}; // fixed even slot per source [RULE3]
      else if (i_brk)
        vec_addr_r <= `VEC_BREAK;
      else if (i_table_call_instruction)
        vec_addr_r <= `TABLE_CALL_INSTRUCTION_BASE + {10'h000, i_table_call_instruction_idx, 1'b0}; // [RULE4]
    end
  end

  // ************************************************************
  // program counter and stack pointer
  // ************************************************************
  // step by length, branch load, vector fetch, short-call target, pops [RULE10]
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      pc_r <= 16'h0000;
    else
    begin
      case (st_r)
        core_regs_pkg::ST_VEC:     pc_r <= vec_word; // [RULE11] [RULE3] [RULE4]
        core_regs_pkg::ST_PSH_PCL: pc_r <= then_vec_r ? pc_r : tgt_r; // [RULE5]
        core_regs_pkg::ST_POP_PCL: pc_r <= {pc_r[15:8], pop_ok ? ram[pop_idx] : 8'h00};
        core_regs_pkg::ST_POP_PCH: pc_r <= {pop_ok ? ram[pop_idx] : 8'h00, pc_r[7:0]};
        core_regs_pkg::ST_IDLE:
        begin
          if (i_pc_load)
            pc_r <= i_pc_target; // [RULE10]
          else if (i_pc_step)
            pc_r <= pc_r + {13'h0000, i_inst_len}; // [RULE10]
        end
        default:                   pc_r <= pc_r;
      endcase
    end
  end

  // pointer moves before each push and after each pop; value after reset is junk to
  // software, zero here only so that the flop has a defined start [RULE20] [RULE21]
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      sp_r <= 16'h0000;
    else if (st_r == core_regs_pkg::ST_PSH_PSW || st_r == core_regs_pkg::ST_PSH_PCH
             || st_r == core_regs_pkg::ST_PSH_PCL)
      sp_r <= sp_dec; // [RULE20]
    else if (st_r == core_regs_pkg::ST_POP_PCL || st_r == core_regs_pkg::ST_POP_PCH
             || st_r == core_regs_pkg::ST_POP_PSW)
      sp_r <= sp_r + 16'h0001; // [RULE20]
    else if (i_wr && i_addr == `SFR_SP_LO)
      sp_r <= {sp_r[15:8], i_wdata};
    else if (i_wr && i_addr == `SFR_SP_HI)
      sp_r <= {i_wdata, sp_r[7:0]};
  end

  // ************************************************************
  // status word
  // ************************************************************
  // sequencer restores beat ALU and control ops, which beat a bus write
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      psw_r <= `STATUS_RESET; // [RULE13]
    else if (st_r == core_regs_pkg::ST_POP_PSW)
      psw_r <= (pop_ok ? ram[pop_idx] : 8'h00) & `STATUS_RSVD_MASK; // [RULE12]
    else if (idle && i_irq_ack)
    begin
      psw_r[`BIT_IE] <= 1'b0; // [RULE14]
      if (i_ack_high)
        psw_r[`BIT_ISP] <= 1'b0; // high-priority service now running
    end
    else if (idle)
    begin
      if (i_di)
        psw_r[`BIT_IE] <= 1'b0; // [RULE14]
      else if (i_ei)
        psw_r[`BIT_IE] <= 1'b1; // [RULE14]
      if (i_sel_bank)
      begin
        psw_r[`BIT_BANK_HI] <= i_bank[1]; // [RULE16] [RULE22]
        psw_r[`BIT_BANK_LO] <= i_bank[0];
      end
      if (i_alu_upd)
      begin
        psw_r[`BIT_Z]  <= (alu_sum[7:0] == 8'h00); // [RULE15]
        psw_r[`BIT_AC] <= alu_sum[4] ^ i_alu_a[4] ^ i_alu_b[4]; // [RULE17]
        psw_r[`BIT_CY] <= alu_sum[8]; // [RULE19]
      end
      else if (i_rot_upd)
        psw_r[`BIT_CY] <= i_shift_out; // [RULE19]
      else if (i_cy_wr)
        psw_r[`BIT_CY] <= i_cy_val; // bit accumulator [RULE19]
      if (!(i_di || i_ei || i_sel_bank || i_alu_upd || i_rot_upd || i_cy_wr)
          && i_wr && i_addr == `SFR_STATUS)
        psw_r <= i_wdata & `STATUS_RSVD_MASK;
    end
    else if (i_wr && i_addr == `SFR_STATUS)
      psw_r <= i_wdata & `STATUS_RSVD_MASK;
  end

  // ************************************************************
  // memories and register banks
  // ************************************************************
  // stack writes take the RAM port first; a bus write in the same cycle is lost
  always_ff @(posedge i_sys_clk)
  begin
    if (st_r == core_regs_pkg::ST_PSH_PSW && push_ok)
      ram[push_idx] <= psw_save_r; // [RULE12]
    else if (st_r == core_regs_pkg::ST_PSH_PCH && push_ok)
      ram[push_idx] <= ret_pc_r[15:8];
    else if (st_r == core_regs_pkg::ST_PSH_PCL && push_ok)
      ram[push_idx] <= ret_pc_r[7:0];
    else if (idle && i_gr_wr)
      ram[bank_base + {7'h00, i_gr_sel}] <= i_gr_wdata; // [RULE7]
    else if (idle && i_rp_wr)
    begin
      ram[bank_base + {7'h00, i_rp_sel, 1'b0}] <= i_rp_wdata[7:0]; // [RULE7]
      ram[bank_base + {7'h00, i_rp_sel, 1'b1}] <= i_rp_wdata[15:8];
    end
    else if (i_wr && in_ram)
      ram[bus_ram_idx] <= i_wdata; // [RULE6]
  end

  // program image is loaded through the bus before i_run
  always_ff @(posedge i_sys_clk)
  begin
    if (i_wr && in_rom)
      rom[15'(i_addr)] <= i_wdata;
  end

  // display cells hold four bits each; upper nibble reads zero [RULE8]
  always_ff @(posedge i_sys_clk)
  begin
    if (i_wr && in_lcd)
      lcd[lcd_idx] <= i_wdata[3:0];
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // read data one cycle after the strobe; unassigned addresses read zero [RULE1] [RULE9]
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else if (in_rom)
      o_rdata <= rom[15'(i_addr)];
    else if (in_lcd)
      o_rdata <= {4'h0, lcd[lcd_idx]}; // [RULE8]
    else if (in_ram)
      o_rdata <= ram[bus_ram_idx];
    else if (i_addr == `SFR_STATUS)
      o_rdata <= psw_r;
    else if (i_addr == `SFR_SP_LO)
      o_rdata <= sp_r[7:0];
    else if (i_addr == `SFR_SP_HI)
      o_rdata <= sp_r[15:8];
    else if (i_addr == `SFR_PC_LO)
      o_rdata <= pc_r[7:0];
    else if (i_addr == `SFR_PC_HI)
      o_rdata <= pc_r[15:8];
    else
      o_rdata <= 8'h00;
  end

  // acceptance gate: NMI always, maskable needs enable, low priority also needs service level 1 [RULE14] [RULE18]
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      o_irq_ok <= 1'b0;
    else
      o_irq_ok <= i_nmi_req || (i_irq_req && psw_r[`BIT_IE]
                                && (psw_r[`BIT_ISP] || !i_irq_low));
  end

  // registered views of the core state and the current bank
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_alu_result <= 8'h00;
      o_gr_byte    <= 8'h00;
      o_gr_pair    <= 16'h0000;
      o_busy       <= 1'b1;
    end
    else
    begin
      o_alu_result <= (idle && i_alu_upd) ? alu_sum[7:0] : o_alu_result;
      o_gr_byte    <= ram[bank_base + {7'h00, i_gr_sel}]; // [RULE7]
      o_gr_pair    <= {ram[bank_base + {7'h00, i_rp_sel, 1'b1}],
                       ram[bank_base + {7'h00, i_rp_sel, 1'b0}]}; // [RULE7]
      o_busy       <= (st_nxt != core_regs_pkg::ST_IDLE);
    end
  end

  assign o_pc  = pc_r;
  assign o_psw = psw_r;
  assign o_sp  = sp_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_push3;
    st_r == core_regs_pkg::ST_PSH_PSW ##1 st_r == core_regs_pkg::ST_PSH_PCH
      ##1 st_r == core_regs_pkg::ST_PSH_PCL;
  endsequence

  a_reset_status: assert property ($past(i_reset) && !i_reset |-> psw_r == 8'h02) // [RULE13]
    else $error("status word not 02 after reset");
  a_ack_sequence: assert property (idle && i_irq_ack |=> s_push3 ##1 // [RULE12]
                                   st_r == core_regs_pkg::ST_VEC)
    else $error("ack did not push three bytes then fetch vector");
  a_ack_stack_depth: assert property (idle && i_irq_ack |-> ##4 // [RULE20]
                                      sp_r == $past(sp_r, 4) - 16'h0003)
    else $error("stack pointer not lowered by three on ack");
  a_di_clears: assert property (idle && i_di |=> !psw_r[`BIT_IE]) // [RULE14]
    else $error("enable flag not cleared");
  a_ack_clears: assert property (idle && i_irq_ack |=> !psw_r[`BIT_IE]) // [RULE14]
    else $error("enable flag survives ack");
  a_zero_flag: assert property (idle && i_alu_upd |=> // [RULE15]
                                psw_r[`BIT_Z] == (o_alu_result == 8'h00))
    else $error("zero flag disagrees with result");
  a_half_carry: assert property (idle && i_alu_upd && !i_alu_sub // [RULE17]
                                 && (i_alu_a[3:0] + i_alu_b[3:0] > 5'h0f) |=> psw_r[`BIT_AC])
    else $error("half carry missed");
  a_short_call_instruction_range: assert property (idle && i_short_call_instruction && !i_irq_ack && !i_brk && !i_push_psw
                                  |-> ##3 pc_r[15:11] == 5'h01) // [RULE5]
    else $error("short call outside its area");
  a_pop_increment: assert property (idle && i_pop_psw && !i_irq_ack && !i_brk // [RULE20]
                                    && !i_push_psw && !i_table_call_instruction && !i_short_call_instruction
                                    |-> ##2 sp_r == $past(sp_r, 2) + 16'h0001)
    else $error("pop did not raise stack pointer");
  a_irq_gate: assert property (!psw_r[`BIT_IE] && !i_nmi_req |=> !o_irq_ok) // [RULE14]
    else $error("maskable accepted while disabled");
  a_low_prio_block: assert property (!psw_r[`BIT_ISP] && i_irq_low && !i_nmi_req // [RULE18]
                                     |=> !o_irq_ok)
    else $error("low priority accepted at service level 0");

endmodule

// *** rtl/core_regs_defines.svh ***
// address map, status word layout, reset values and stack constants
`ifndef CORE_REGS_DEFINES_SVH
`define CORE_REGS_DEFINES_SVH
`define ROM_LAST       16'h7fff
`define VEC_RESET      16'h0000
`define VEC_WATCHDOG   16'h0004
`define VEC_LAST_PERI  16'h0028
`define VEC_BREAK      16'h003e
`define VEC_TOP        16'h003f
`define TABLE_CALL_INSTRUCTION_BASE     16'h0040
`define TABLE_CALL_INSTRUCTION_TOP      16'h007f
`define SHORT_CALL_INSTRUCTION_BASE     16'h0800
`define SHORT_CALL_INSTRUCTION_TOP      16'h0fff
`define LCD_BASE       16'hfa58
`define LCD_TOP        16'hfa7f
`define LCD_DEPTH      40
`define RAM_BASE       16'hfb00
`define RAM_TOP        16'hfeff
`define RAM_DEPTH      1024
`define GREG_BASE      10'h3e0
`define SFR_BASE       16'hff00
`define SFR_SP_LO      16'hff1c
`define SFR_SP_HI      16'hff1d
`define SFR_STATUS     16'hff1e
`define SFR_PC_LO      16'hfffc
`define SFR_PC_HI      16'hfffd
`define STATUS_RESET   8'h02
`define STATUS_RSVD_MASK 8'hfb
`define BIT_IE         7
`define BIT_Z          6
`define BIT_BANK_HI    5
`define BIT_AC         4
`define BIT_BANK_LO    3
`define BIT_ISP        1
`define BIT_CY         0
`endif

// *** rtl/core_regs_pkg.sv ***
// types shared by the core register block
package core_regs_pkg;
  typedef enum logic [3:0] {
    ST_BOOT, ST_IDLE, ST_VEC, ST_PSH_PSW, ST_PSH_PCH, ST_PSH_PCL,
    ST_POP_PCL, ST_POP_PCH, ST_POP_PSW
  } seq_state_type;
endpackage

// *** testbench/irq_source_model.sv ***
// interrupt acknowledge model facing the core register block
`timescale 1ns/1ps
module irq_source_model (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_ok,
  input  wire logic i_busy,
  input  wire logic i_want,
  output logic      o_ack
);
  // ************************************************************
  // acknowledge
  // ************************************************************
  // one ack per accepted request while the core is idle; the forced gap
  // after a pulse avoids a second ack before busy has risen
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      o_ack <= 1'b0;
    else
      o_ack <= i_want & i_ok & ~i_busy & ~o_ack;
  end
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the core register block
`timescale 1ns/1ps
module testbench;
  logic        i_sys_clk, i_reset, i_wr, i_rd, i_run, i_ack_high, i_alu_sub, o_irq_ok;
  logic        i_shift_out, i_cy_val, i_irq_req, i_irq_low, i_nmi_req, want, ack, o_busy;
  logic [15:0] i_addr, i_pc_target, i_rp_wdata, o_pc, o_sp, o_gr_pair;
  logic [7:0]  i_wdata, i_alu_a, i_alu_b, i_gr_wdata, o_rdata, o_psw, o_alu_result, o_gr_byte;
  logic [4:0]  i_vec_slot, i_table_call_instruction_idx;
  logic [10:0] i_short_call_instruction_addr;
  logic [2:0]  i_inst_len, i_gr_sel;
  logic [1:0]  i_bank, i_rp_sel;
  logic [16:0] cmd;
  int          err_total, total_checks, cyc;

  // command strobes travel as one vector so a single task can pulse any of them
  core_regs u_core_regs (.*, .i_irq_ack(ack),
    .i_pc_step(cmd[0]), .i_pc_load(cmd[1]), .i_brk(cmd[2]), .i_table_call_instruction(cmd[3]),
    .i_short_call_instruction(cmd[4]), .i_push_psw(cmd[5]), .i_pop_psw(cmd[6]), .i_ret(cmd[7]),
    .i_interrupt_return_instruction(cmd[8]), .i_di(cmd[9]), .i_ei(cmd[10]), .i_sel_bank(cmd[11]),
    .i_alu_upd(cmd[12]), .i_rot_upd(cmd[13]), .i_cy_wr(cmd[14]), .i_gr_wr(cmd[15]),
    .i_rp_wr(cmd[16]));
  irq_source_model u_irq_source_model (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_ok(o_irq_ok), .i_busy(o_busy), .i_want(want), .o_ack(ack));

  // ************************************************************
  // clock, watchdog and shared tasks
  // ************************************************************
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // the whole run needs well under 1000 cycles
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      $display("unexpected at %0t: run hung", $time);
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  // busy is registered, so one more edge lets the acceptance gate settle
  task automatic idle;
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 40)
    begin
      tick(1);
      n++;
    end
    ck(n < 40, 1'b1);
    tick(1);
  endtask

  task automatic go(input int b);
    @(posedge i_sys_clk);
    cmd[b] <= 1'b1;
    @(posedge i_sys_clk);
    cmd <= '0;
    #1;
    idle();
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    ck(o_rdata, e);
  endtask

  task automatic alu(input logic [7:0] a, b, input logic s, input logic [7:0] r, p);
    i_alu_a <= a;
    i_alu_b <= b;
    i_alu_sub <= s;
    go(12);
    ck(o_alu_result, r);
    ck(o_psw, p);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    {i_wr, i_rd, i_run, i_ack_high, i_alu_sub, i_shift_out, i_cy_val, i_irq_req} = '0;
    {i_irq_low, i_nmi_req, want, i_addr, i_pc_target, i_rp_wdata, i_wdata} = '0;
    {i_alu_a, i_alu_b, i_gr_wdata, i_vec_slot, i_table_call_instruction_idx, i_short_call_instruction_addr} = '0;
    {i_inst_len, i_gr_sel, i_bank, i_rp_sel, cmd} = '0;
    i_reset = 1'b1;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    ck(o_psw, 8'h02);
    // vector words go in low byte first: reset, slot 2 and table entry 1
    wr(16'h0000, 8'h34);
    wr(16'h0001, 8'h12);
    wr(16'h0004, 8'h00);
    wr(16'h0005, 8'h20);
    wr(16'h0042, 8'h78);
    wr(16'h0043, 8'h56);
    rd(16'h0001, 8'h12);
    i_run <= 1'b1;
    #1;
    idle();
    ck(o_pc, 16'h1234);
    $display("done: boot");
    i_inst_len <= 3'h3;
    go(0);
    ck(o_pc, 16'h1237);
    i_pc_target <= 16'h3000;
    go(1);
    ck(o_pc, 16'h3000);
    wr(16'hfffd, 8'h11);
    rd(16'hfffd, 8'h30);
    $display("done: counter");
    wr(16'hff1c, 8'h00);
    wr(16'hff1d, 8'hfe);
    go(5);
    ck(o_sp, 16'hfdff);
    rd(16'hfdff, 8'h02);
    go(10);
    rd(16'hff1e, 8'h82);
    alu(8'h0f, 8'h01, 1'b0, 8'h10, 8'h92);
    alu(8'h80, 8'h80, 1'b0, 8'h00, 8'hc3);
    alu(8'h10, 8'h01, 1'b1, 8'h0f, 8'h92);
    i_cy_val <= 1'b1;
    go(14);
    ck(o_psw, 8'h93);
    go(13);
    ck(o_psw, 8'h92);
    go(6);
    ck(o_psw, 8'h02);
    ck(o_sp, 16'hfe00);
    $display("done: stack and flags");
    go(10);
    i_irq_req <= 1'b1;
    i_vec_slot <= 5'h02;
    i_ack_high <= 1'b1;
    want <= 1'b1;
    while (ack !== 1'b1 && cyc < 3000)
      tick(1);
    want <= 1'b0;
    tick(2);
    idle();
    ck(o_pc, 16'h2000);
    ck(o_psw, 8'h00);
    ck(o_sp, 16'hfdfd);
    rd(16'hfdff, 8'h82);
    rd(16'hfdfe, 8'h30);
    i_irq_low <= 1'b1;
    go(10);
    ck(o_irq_ok, 1'b0);
    i_irq_low <= 1'b0;
    tick(2);
    ck(o_irq_ok, 1'b1);
    go(9);
    ck(o_irq_ok, 1'b0);
    i_nmi_req <= 1'b1;
    tick(2);
    ck(o_irq_ok, 1'b1);
    i_nmi_req <= 1'b0;
    i_irq_req <= 1'b0;
    go(8);
    ck(o_pc, 16'h3000);
    ck(o_psw, 8'h82);
    $display("done: interrupt");
    i_short_call_instruction_addr <= 11'h123;
    go(4);
    ck(o_pc, 16'h0923);
    i_table_call_instruction_idx <= 5'h01;
    go(3);
    ck(o_pc, 16'h5678);
    go(7);
    ck(o_pc, 16'h0923);
    go(7);
    ck(o_sp, 16'hfe00);
    // break fetches its own slot and returns through the interrupt return path
    wr(16'h003e, 8'h21);
    wr(16'h003f, 8'h43);
    go(2);
    ck(o_pc, 16'h4321);
    ck(o_sp, 16'hfdfd);
    go(8);
    ck(o_pc, 16'h3000);
    ck(o_psw, 8'h82);
    $display("done: calls");
    wr(16'hfb00, 8'h3c);
    rd(16'hfb00, 8'h3c);
    wr(16'hfa58, 8'h05);
    rd(16'hfa58, 8'h05);
    // software side touches only assigned registers in the window
    wr(16'hff1c, 8'h40);
    rd(16'hff1c, 8'h40);
    i_bank <= 2'h2;
    go(11);
    ck({o_psw[5], o_psw[3]}, 2'b10);
    i_gr_wdata <= 8'ha5;
    i_gr_sel <= 3'h1;
    go(15);
    rd(16'hfef1, 8'ha5);
    ck(o_gr_byte, 8'ha5);
    wr(16'hfef0, 8'h5a);
    rd(16'hfef0, 8'h5a);
    ck(o_gr_pair, 16'ha55a);
    // pair 1 of bank 2 is R2 low and R3 high
    i_rp_sel <= 2'h1;
    i_rp_wdata <= 16'hbeef;
    go(16);
    rd(16'hfef3, 8'hbe);
    rd(16'hfef2, 8'hef);
    ck(o_gr_pair, 16'hbeef);
    $display("done: memory and banks");
    wrap_up();
  end
endmodule
